/* bench/tb_vcab_regs.sv */
// self-checking bench for the ancillary buffer register bank
`timescale 1ns/1ps
module tb_vcab_regs;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [63:0] bottom_hanc_addr_field, top_vanc_addr_field;
	logic [63:0] bottom_vanc_addr_field;
	logic [15:0] subpic_hstart_pos;
	logic [17:0] subpic_hsize;
	int fail_count = 0, check_count = 0, cyc = 0;
	logic [31:0] w;
	logic [16:0] sp;
	always #10 aclk = ~aclk;
	vcab_regs #(.CHANNELS(2)) vcab_regs_inst
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .bottom_hanc_addr_field,
		.top_vanc_addr_field, .bottom_vanc_addr_field, .subpic_hstart_pos,
		.subpic_hsize
	);
	////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task chk(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// bus cycles: handshakes taken at the rising edge; ready stays high
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		logic hb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		hb = 1'b0;
		while (!hb)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			hb = s_axi_bvalid;
			if (hb)
				chk({s_axi_bresp, 32'h0}, {r, 32'h0});
		end
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		logic hr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		hr = 1'b0;
		while (!hr)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			hr = s_axi_rvalid;
			if (hr)
				chk({s_axi_rresp, s_axi_rdata}, {r, e});
		end
	endtask : rd
	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), 32'h0, 2'h0);
		// aligned addresses; legal sub-picture fields, reserved bits set
		for (int i = 0; i < 8; i++)
		begin
			w = i % 4 == 3 ? 32'hfff8_ff00 : 32'hffff_fff8;
			wr(8'(i * 4), w, 4'hf, 2'h0);
		end
		for (int i = 0; i < 8; i++)
		begin
			w = i % 4 == 3 ? 32'h00f8_0100 : 32'hffff_fff8;
			rd(8'(i * 4), w, 2'h0);
		end
		wr(8'h14, 32'h1234_5678, 4'h3, 2'h0);
		rd(8'h14, 32'hffff_5678, 2'h0);
		for (int i = 0; i < 8; i++)
		begin
			w = i % 4 == 3 ? 32'h0008_0020 << (i / 4)
				: 32'h0101_0008 * (i + 1);
			wr(8'(i * 4), w, 4'hf, 2'h0);
		end
		for (int c = 0; c < 2; c++)
		begin
			w = 32'h0101_0008 * (c * 4 + 1);
			chk(bottom_hanc_addr_field[c*32+:32], w);
			chk(top_vanc_addr_field[c*32+:32], w + 32'h0101_0008);
			chk(bottom_vanc_addr_field[c*32+:32], w + 32'h0202_0010);
			sp = {subpic_hstart_pos[c*8+:8], subpic_hsize[c*9+:9]};
			chk(sp, {8'h08, 9'h020} << c);
			rd(8'(c * 16 + 12), 32'h0008_0020 << c, 2'h0);
		end
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h02, 32'h5, 4'hf, 2'h2);
		rd(8'h00, 32'h0101_0008, 2'h0);
		stop_test();
	end
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			stop_test();
		end
	end
endmodule : tb_vcab_regs

/* bench/vcab_regs_assertions.sv */
// checker for the ancillary buffer register bank
`timescale 1ns/1ps
module vcab_regs_chk
#(
	parameter int CHANNELS = 2
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// read address, read data and write response
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_bvalid,
	// register contents
	input wire logic [CHANNELS*32-1:0] bottom_hanc_addr_field,
	input wire logic [CHANNELS*32-1:0] top_vanc_addr_field,
	input wire logic [CHANNELS*32-1:0] bottom_vanc_addr_field,
	input wire logic [CHANNELS*8-1:0] subpic_hstart_pos,
	input wire logic [CHANNELS*9-1:0] subpic_hsize
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic ar;
	assign ar = s_axi_arvalid && s_axi_arready;
	property p_bhanc;
		ar && s_axi_araddr == 8'h00 |=>
			s_axi_rdata == $past(bottom_hanc_addr_field[31:0]);
	endproperty
	a_bhanc: assert property (p_bhanc)
		else $error("bottom hanc readback wrong");
	property p_tvanc;
		ar && s_axi_araddr == 8'h14 |=>
			s_axi_rdata == $past(top_vanc_addr_field[63:32]);
	endproperty
	a_tvanc: assert property (p_tvanc)
		else $error("top vanc readback wrong");
	property p_bvanc;
		ar && s_axi_araddr == 8'h08 |=>
			s_axi_rdata == $past(bottom_vanc_addr_field[31:0]);
	endproperty
	a_bvanc: assert property (p_bvanc)
		else $error("bottom vanc readback wrong");
	property p_subpic;
		ar && s_axi_araddr == 8'h1c |=> s_axi_rdata == {8'h00,
			$past(subpic_hstart_pos[15:8]), 7'h00, $past(subpic_hsize[17:9])};
	endproperty
	a_subpic: assert property (p_subpic)
		else $error("sub-picture readback wrong");
	property p_hold;
		!$rose(s_axi_bvalid) |-> $stable(bottom_hanc_addr_field)
			&& $stable(subpic_hsize);
	endproperty
	a_hold: assert property (p_hold)
		else $error("register changed without a write");
	property p_rst;
		disable iff (1'b0) !aresetn |=> top_vanc_addr_field == '0
			&& subpic_hstart_pos == '0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("register not cleared by reset");
	property p_err;
		ar && s_axi_araddr[7:4] > 4'h1 |=> s_axi_rresp == 2'h2
			&& s_axi_rdata == 32'h0;
	endproperty
	a_err: assert property (p_err)
		else $error("unmapped read not refused");
	c_rd: cover property (ar && s_axi_araddr == 8'h1c);
	c_wr: cover property ($rose(s_axi_bvalid));
	c_err: cover property (ar && s_axi_araddr == 8'h20);
endmodule : vcab_regs_chk
////////////////////////////////////////////////////////////////////////
bind vcab_regs vcab_regs_chk #(.CHANNELS(CHANNELS)) vcab_regs_chk_inst
(
	.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_bvalid, .bottom_hanc_addr_field,
	.top_vanc_addr_field, .bottom_vanc_addr_field, .subpic_hstart_pos,
	.subpic_hsize
);

/* logic/vcab_cfg.svh */
// register map, field positions and reset values of the ancillary buffer bank
`ifndef VCAB_CFG_SVH
`define VCAB_CFG_SVH
`define VCAB_CH_STRIDE 8'h10
`define VCAB_OFS_BHANC 8'h00
`define VCAB_OFS_TVANC 8'h04
`define VCAB_OFS_BVANC 8'h08
`define VCAB_OFS_SUBPIC 8'h0c
`define VCAB_SP_HSTART_MSB 23
`define VCAB_SP_HSTART_LSB 16
`define VCAB_SP_HSIZE_MSB 8
`define VCAB_SP_HSIZE_LSB 0
`define VCAB_RST_ADDR 32'h0000_0000
`define VCAB_RST_SUBPIC 32'h0000_0000
`define VCAB_SUBPIC_MASK 32'h00ff_01ff
`define VCAB_RESP_OKAY 2'h0
`define VCAB_RESP_SLVERR 2'h2
`endif

/* logic/vcab_chan_if.sv */
// write strobe and contents of one channel's register set
`timescale 1ns/1ps
interface vcab_chan_if;
	logic [1:0] sel;
	logic wr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	vcab_pkg::vcab_chan_s regs;
	modport bank (input sel, input wr, input wdata, input wstrb, output regs);
	modport ctrl (output sel, output wr, output wdata, output wstrb,
		input regs);
endinterface : vcab_chan_if

/* logic/vcab_chan_regs.sv */
// one channel's ancillary start address and sub-picture registers
`timescale 1ns/1ps
`include "vcab_cfg.svh"
module vcab_chan_regs
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register access
	vcab_chan_if.bank port
);
	vcab_pkg::vcab_chan_s state_q;
	vcab_pkg::vcab_chan_s state_d;
	logic [31:0] sub_old;
	logic [31:0] sub_new;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	always_comb
	begin
		state_d = state_q;
		sub_old = 32'h0000_0000;
		sub_old[`VCAB_SP_HSTART_MSB:`VCAB_SP_HSTART_LSB] =
			state_q.subpic_hstart_pos;
		sub_old[`VCAB_SP_HSIZE_MSB:`VCAB_SP_HSIZE_LSB] = state_q.subpic_hsize;
		sub_new = merge(sub_old, port.wdata, port.wstrb);
		if (port.wr)
		begin
			case (port.sel)
				2'h0: state_d.bottom_hanc_buffer_start = merge(
					state_q.bottom_hanc_buffer_start, port.wdata, port.wstrb);
				2'h1: state_d.top_vanc_buffer_start = merge(
					state_q.top_vanc_buffer_start, port.wdata, port.wstrb);
				2'h2: state_d.bottom_vanc_buffer_start = merge(
					state_q.bottom_vanc_buffer_start, port.wdata, port.wstrb);
				2'h3:
				begin
					state_d.subpic_hstart_pos =
						sub_new[`VCAB_SP_HSTART_MSB:`VCAB_SP_HSTART_LSB];
					state_d.subpic_hsize =
						sub_new[`VCAB_SP_HSIZE_MSB:`VCAB_SP_HSIZE_LSB];
				end
				default: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign port.regs = state_q;
endmodule : vcab_chan_regs

/* logic/vcab_pkg.sv */
// types shared by the ancillary buffer register bank
package vcab_pkg;
	typedef logic [31:0] vcab_word_t;
	typedef struct packed
	{
		vcab_word_t bottom_hanc_buffer_start;
		vcab_word_t top_vanc_buffer_start;
		vcab_word_t bottom_vanc_buffer_start;
		logic [7:0] subpic_hstart_pos;
		logic [8:0] subpic_hsize;
	} vcab_chan_s;
endpackage : vcab_pkg

/* logic/vcab_regs.sv */
// two-channel ancillary buffer register bank behind an axi4-lite slave
// How it works
// - bottom hanc data starts at its register
// - top vanc data starts at its register
// - bottom vanc data starts at its register
// - bottom vanc address used for progressive too
// - start registers: 32-bit read/write, reset zero
// - sub-picture: start 23:16, size 8:0
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "vcab_cfg.svh"
module vcab_regs
#(
	parameter int CHANNELS = 2
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// start addresses and sub-picture fields to the capture write-address generator
	output logic [CHANNELS*32-1:0] bottom_hanc_addr_field,
	output logic [CHANNELS*32-1:0] top_vanc_addr_field,
	output logic [CHANNELS*32-1:0] bottom_vanc_addr_field,
	output logic [CHANNELS*8-1:0] subpic_hstart_pos,
	output logic [CHANNELS*9-1:0] subpic_hsize
);
	typedef struct packed
	{
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} vcab_bus_s;

	vcab_bus_s state_q;
	vcab_bus_s state_d;
	logic do_write;
	logic wr_hit;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [CHANNELS-1:0] ch_wr;
	logic [2:0] wr_dec;
	logic [2:0] rd_dec;
	logic [7:0] wr_ch;
	logic [7:0] rd_ch;
	vcab_pkg::vcab_chan_s ch_regs [CHANNELS];

	vcab_chan_if chan [CHANNELS] ();

	////////////////////////////////////////////////////////////////////////
	// address decode against the register map
	// bit 2 marks a mapped offset, bits 1:0 pick the register
	function automatic logic [2:0] ofs_decode(input logic [7:0] addr);
		logic [7:0] ofs;
		logic [2:0] r;
		ofs = addr % `VCAB_CH_STRIDE;
		case (ofs)
			`VCAB_OFS_BHANC: r = 3'h4;
			`VCAB_OFS_TVANC: r = 3'h5;
			`VCAB_OFS_BVANC: r = 3'h6;
			`VCAB_OFS_SUBPIC: r = 3'h7;
			default: r = 3'h0;
		endcase
		return r;
	endfunction : ofs_decode

	// channel number and register of both requests
	assign wr_dec = ofs_decode(state_q.awaddr);
	assign rd_dec = ofs_decode(s_axi_araddr);
	assign wr_ch = state_q.awaddr / `VCAB_CH_STRIDE;
	assign rd_ch = s_axi_araddr / `VCAB_CH_STRIDE;

	////////////////////////////////////////////////////////////////////////
	// per-channel banks and outputs
	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_ch
		assign chan[c].sel = wr_dec[1:0];
		assign chan[c].wr = ch_wr[c];
		assign chan[c].wdata = state_q.wdata;
		assign chan[c].wstrb = state_q.wstrb;
		vcab_chan_regs u_regs
		(
			.aclk(aclk),
			.aresetn(aresetn),
			.port(chan[c])
		);
		assign bottom_hanc_addr_field[c*32 +: 32] =
			chan[c].regs.bottom_hanc_buffer_start;
		assign top_vanc_addr_field[c*32 +: 32] =
			chan[c].regs.top_vanc_buffer_start;
		assign bottom_vanc_addr_field[c*32 +: 32] =
			chan[c].regs.bottom_vanc_buffer_start;
		assign subpic_hstart_pos[c*8 +: 8] = chan[c].regs.subpic_hstart_pos;
		assign subpic_hsize[c*9 +: 9] = chan[c].regs.subpic_hsize;
		// channel contents for the read mux
		assign ch_regs[c] = chan[c].regs;
		assign ch_wr[c] = do_write && wr_hit &&
			(wr_ch == 8'(c));
	end

	////////////////////////////////////////////////////////////////////////
	// read mux over all channels
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b0;
		for (int c = 0; c < CHANNELS; c++)
		begin
			if (rd_dec[2] && rd_ch == 8'(c))
			begin
				rd_hit = 1'b1;
				case (rd_dec[1:0])
					2'h0: rd_word = ch_regs[c].bottom_hanc_buffer_start;
					2'h1: rd_word = ch_regs[c].top_vanc_buffer_start;
					2'h2: rd_word = ch_regs[c].bottom_vanc_buffer_start;
					2'h3: rd_word = {8'h00, ch_regs[c].subpic_hstart_pos,
						7'h00, ch_regs[c].subpic_hsize};
					default: rd_word = 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite handshakes
	assign s_axi_awready = !state_q.aw_held && !state_q.bvalid;
	assign s_axi_wready = !state_q.w_held && !state_q.bvalid;
	assign s_axi_arready = !state_q.rvalid;
	// commit once address and data are both held
	assign do_write = state_q.aw_held && state_q.w_held && !state_q.bvalid;
	assign wr_hit = wr_dec[2] &&
		32'(wr_ch) < CHANNELS;

	always_comb
	begin
		state_d = state_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			state_d.aw_held = 1'b1;
			state_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			state_d.w_held = 1'b1;
			state_d.wdata = s_axi_wdata;
			state_d.wstrb = s_axi_wstrb;
		end
		if (do_write)
		begin
			state_d.aw_held = 1'b0;
			state_d.w_held = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = wr_hit ? `VCAB_RESP_OKAY : `VCAB_RESP_SLVERR;
		end
		if (state_q.bvalid && s_axi_bready)
		begin
			state_d.bvalid = 1'b0;
		end
		if (state_q.rvalid && s_axi_rready)
		begin
			state_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			state_d.rvalid = 1'b1;
			state_d.rdata = rd_word;
			state_d.rresp = rd_hit ? `VCAB_RESP_OKAY : `VCAB_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_rvalid = state_q.rvalid;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
endmodule : vcab_regs
